// ===== common/tki2c_pkg.sv
package tki2c_pkg;
	// ==========================================================
	// Bus address
	localparam logic [4:0] TKI2C_ADDR_HI     = 5'h11;
	localparam logic [1:0] TKI2C_STRAP_GND   = 2'h0;
	localparam logic [1:0] TKI2C_STRAP_VCC   = 2'h3;
	localparam logic [1:0] TKI2C_STRAP_SCL   = 2'h1;
	localparam logic [1:0] TKI2C_STRAP_SDA   = 2'h2;
	// ==========================================================
	// Register indices and reset values
	localparam logic [7:0] TKI2C_REG_CFG     = 8'h00;
	localparam logic [7:0] TKI2C_REG_CHEN    = 8'h01;
	localparam logic [7:0] TKI2C_REG_PRESS   = 8'h02;
	localparam logic [7:0] TKI2C_REG_CHANGE  = 8'h03;
	localparam logic [7:0] TKI2C_REG_IRQCFG  = 8'h04;
	localparam logic [7:0] TKI2C_CFG_RST     = 8'h00;
	localparam logic [7:0] TKI2C_CHEN_RST    = 8'hff;
	localparam logic [7:0] TKI2C_IRQCFG_RST  = 8'h00;
	// Fields
	localparam int         TKI2C_SPD_BIT     = 7;
	localparam int         TKI2C_SENS_LSB    = 5;
	localparam int         TKI2C_ACI_LSB     = 6;
	localparam logic [1:0] TKI2C_ACI_OFF     = 2'h0;
	localparam logic [1:0] TKI2C_ACI_8MS     = 2'h1;
	localparam logic [1:0] TKI2C_ACI_32MS    = 2'h2;
	localparam logic [1:0] TKI2C_SENS_BAD    = 2'h3;
	// ==========================================================
	// Timing at 125 MHz
	localparam int         TKI2C_CLK_KHZ     = 125000;
	localparam int         TKI2C_T8_MS       = 8;
	localparam int         TKI2C_T32_MS      = 32;
	localparam int         TKI2C_T8_CYC      = TKI2C_T8_MS * TKI2C_CLK_KHZ;
	localparam int         TKI2C_T32_CYC     = TKI2C_T32_MS * TKI2C_CLK_KHZ;
	// Host bit timing: half period of SCL, 400 kHz at most
	localparam int         TKI2C_HALF_NS     = 1250;
	localparam int         TKI2C_HALF_CYC    = (TKI2C_HALF_NS + 7) / 8;
	// Host command/status registers (APB)
	localparam logic [7:0] TKI2C_H_CTRL      = 8'h00;
	localparam logic [7:0] TKI2C_H_STAT      = 8'h04;
	localparam logic [7:0] TKI2C_H_RDATA     = 8'h08;
endpackage

// ===== common/tki2c_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tki2c_if;
	logic scl_o;
	logic scl_oe_n;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_s_o;
	logic sda_s_oe_n;
	wire  scl = scl_oe_n ? 1'b1 : scl_o;
	wire  sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

	modport device (input scl, input sda, output sda_s_o, output sda_s_oe_n);
	modport host   (input scl, input sda, output scl_o, output scl_oe_n,
	                output sda_m_o, output sda_m_oe_n);
endinterface
`default_nettype wire

// ===== src/tki2c_device.sv
// Added by the designer: the APB slave port is in tki2c_host, not here.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Answer address 10001 plus two strap bits
// - Strap straps map to 00,11,01,10
// - Address LSB zero writes, one reads
// - Sample data while clock high; idle high
// - Master frames with START and STOP
// - Acknowledge matching address on ninth clock
// - Master stops after missing acknowledge
// - Write: index then data, each acknowledged
// - Read: index write, restart, read data
// - Config bit 7 sets software power down
// - Config bits 6:5 select sensitivity
// - Channel enable bits, all enabled at reset
// - Press register shows pressed channels
// - Change register flags press/release events
// - Indicator pin low while channel pressed
// - Interrupt low on any press or release
// - Interrupt released by change register read
// - Auto release after 8 or 32 ms
// - Registers kept during power down
// - Hardware power down while pin low
module tki2c_device
	import tki2c_pkg::*;
#(
	parameter int T8_CYC  = tki2c_pkg::TKI2C_T8_CYC,
	parameter int T32_CYC = tki2c_pkg::TKI2C_T32_CYC
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	// Link
	tki2c_if.device         bus,
	// Chip pins
	input  wire logic [1:0] strap_i,
	input  wire logic [7:0] sense_input_i,
	input  wire logic       hard_power_down_n_i,
	output logic      [7:0] press_indicator_n_o,
	output logic      [7:0] press_indicator_oe_n_o,
	output logic            event_irq_n_o,
	output logic            event_irq_oe_n_o,
	output logic      [1:0] sense_level_o
);
	import tki2c_pkg::*;

	typedef enum {S_IDLE, S_ADDR, S_AACK, S_IDX, S_IACK, S_DATA, S_DACK,
	              S_RD, S_RACK} tki2c_st_type;

	// ==========================================================
	// Line sampling and edges
	logic       scl_q_r, sda_q_r, scl_p_r, sda_p_r;
	logic       scl_rise, scl_fall, start_c, stop_c;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			scl_q_r <= 1'b1; sda_q_r <= 1'b1; scl_p_r <= 1'b1; sda_p_r <= 1'b1;
		end else begin
			scl_q_r <= bus.scl; sda_q_r <= bus.sda; scl_p_r <= scl_q_r; sda_p_r <= sda_q_r;
		end
	end
	assign scl_rise = scl_q_r & ~scl_p_r;
	assign scl_fall = ~scl_q_r & scl_p_r;
	assign start_c  = scl_q_r & scl_p_r & sda_p_r & ~sda_q_r;
	assign stop_c   = scl_q_r & scl_p_r & ~sda_p_r & sda_q_r;

	// ==========================================================
	// Serial engine and registers
	tki2c_st_type st_r, st_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt, idx_r, idx_nxt;
	logic [7:0] cfg_r, cfg_nxt, chen_r, chen_nxt, irqc_r, irqc_nxt;
	logic [7:0] press_r, press_nxt, chg_r, chg_nxt;
	logic       sda_oe_n_r, sda_oe_n_nxt, rd_chg;
	logic [7:0] addr_w;
	logic       run;
	logic [7:0] rd_byte;

	function automatic logic [7:0] reg_read(input logic [7:0] i, input logic [7:0] c,
		input logic [7:0] e, input logic [7:0] p, input logic [7:0] g, input logic [7:0] q);
		unique case (i)
			TKI2C_REG_CFG:    reg_read = c;
			TKI2C_REG_CHEN:   reg_read = e;
			TKI2C_REG_PRESS:  reg_read = p;
			TKI2C_REG_CHANGE: reg_read = g;
			TKI2C_REG_IRQCFG: reg_read = q;
			default:          reg_read = 8'h00;
		endcase
	endfunction

	assign addr_w = {TKI2C_ADDR_HI, strap_i, 1'b0}; // strap encoded by board
	assign run    = hard_power_down_n_i & ~cfg_r[TKI2C_SPD_BIT];
	assign rd_byte = reg_read(idx_r, cfg_r, chen_r, press_r, chg_r, irqc_r);

	always_comb begin
		st_nxt = st_r; bit_nxt = bit_r; sh_nxt = sh_r; idx_nxt = idx_r;
		cfg_nxt = cfg_r; chen_nxt = chen_r; irqc_nxt = irqc_r;
		sda_oe_n_nxt = sda_oe_n_r; rd_chg = 1'b0;
		if (!hard_power_down_n_i) begin
			st_nxt = S_IDLE; sda_oe_n_nxt = 1'b1; // registers untouched
		end else if (start_c) begin
			st_nxt = S_ADDR; bit_nxt = 4'h0; sda_oe_n_nxt = 1'b1; // restart too
		end else if (stop_c) begin
			st_nxt = S_IDLE; sda_oe_n_nxt = 1'b1;
		end else if (scl_rise) begin
			unique case (st_r)
				S_ADDR, S_IDX, S_DATA: begin
					sh_nxt  = {sh_r[6:0], sda_q_r}; // MSB first
					bit_nxt = bit_r + 4'h1;
				end
				S_RACK: if (sda_q_r) st_nxt = S_IDLE; // Master NAK ends read
				default: ;
			endcase
		end else if (scl_fall) begin
			unique case (st_r)
				S_ADDR: if (bit_r == 4'h8) begin
					if (sh_r[7:1] == addr_w[7:1]) begin
						st_nxt = S_AACK; sda_oe_n_nxt = 1'b0;
					end else st_nxt = S_IDLE;
				end
				S_AACK: begin
					bit_nxt = 4'h0;
					if (sh_r[0]) begin // read
						st_nxt = S_RD; sh_nxt = rd_byte;
						sda_oe_n_nxt = rd_byte[7];
						rd_chg = (idx_r == TKI2C_REG_CHANGE);
					end else begin
						st_nxt = S_IDX; sda_oe_n_nxt = 1'b1;
					end
				end
				S_IDX: if (bit_r == 4'h8) begin
					idx_nxt = sh_r; st_nxt = S_IACK; sda_oe_n_nxt = 1'b0;
				end
				S_IACK: begin st_nxt = S_DATA; bit_nxt = 4'h0; sda_oe_n_nxt = 1'b1; end
				S_DATA: if (bit_r == 4'h8) begin
					st_nxt = S_DACK; sda_oe_n_nxt = 1'b0;
					unique case (idx_r)
						TKI2C_REG_CFG:    cfg_nxt  = {sh_r[7:5], 5'h00};
						TKI2C_REG_CHEN:   chen_nxt = sh_r;
						TKI2C_REG_IRQCFG: irqc_nxt = {sh_r[7:6], 6'h00};
						default: ;
					endcase
				end
				S_DACK: begin st_nxt = S_DATA; bit_nxt = 4'h0; sda_oe_n_nxt = 1'b1; end
				S_RD: begin
					bit_nxt = bit_r + 4'h1;
					if (bit_r == 4'h7) begin st_nxt = S_RACK; sda_oe_n_nxt = 1'b1; end
					else begin sh_nxt = {sh_r[6:0], 1'b0}; sda_oe_n_nxt = sh_r[6]; end
				end
				S_RACK: begin
					st_nxt = S_RD; bit_nxt = 4'h0;
					sh_nxt = rd_byte;
					sda_oe_n_nxt = rd_byte[7];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			st_r <= S_IDLE; bit_r <= 4'h0; sh_r <= 8'h00; idx_r <= 8'h00;
			cfg_r <= TKI2C_CFG_RST; chen_r <= TKI2C_CHEN_RST; irqc_r <= TKI2C_IRQCFG_RST;
			sda_oe_n_r <= 1'b1;
		end else begin
			st_r <= st_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt; idx_r <= idx_nxt;
			cfg_r <= cfg_nxt; chen_r <= chen_nxt; irqc_r <= irqc_nxt;
			sda_oe_n_r <= sda_oe_n_nxt;
		end
	end
	assign bus.sda_s_o    = 1'b0;
	assign bus.sda_s_oe_n = sda_oe_n_r;

	// ==========================================================
	// Channel state, change flags, interrupt
	logic [7:0] det;
	logic       irq_n_r, irq_n_nxt;
	logic [31:0] tmo_r, tmo_nxt;
	logic [1:0]  irq_auto_release;
	assign det = sense_input_i & chen_r;
	assign irq_auto_release = irqc_r[TKI2C_ACI_LSB +: 2];

	always_comb begin
		press_nxt = press_r; chg_nxt = chg_r; irq_n_nxt = irq_n_r; tmo_nxt = tmo_r;
		if (rd_chg) begin
			chg_nxt = 8'h00; irq_n_nxt = 1'b1;
		end
		if (!irq_n_r && irq_auto_release != TKI2C_ACI_OFF && irq_auto_release != TKI2C_SENS_BAD) begin
			tmo_nxt = tmo_r + 32'd1;
			if ((irq_auto_release == TKI2C_ACI_8MS && tmo_r >= 32'(T8_CYC - 1)) ||
			    (irq_auto_release == TKI2C_ACI_32MS && tmo_r >= 32'(T32_CYC - 1))) irq_n_nxt = 1'b1;
		end
		if (irq_n_nxt) tmo_nxt = 32'd0;
		if (run && det != press_r) begin // frozen while down
			press_nxt = det;
			chg_nxt   = chg_nxt | (det ^ press_r); // set beats clear
			irq_n_nxt = 1'b0; tmo_nxt = 32'd0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			press_r <= 8'h00; chg_r <= 8'h00; irq_n_r <= 1'b1; tmo_r <= 32'd0;
			press_indicator_oe_n_o <= 8'hff; event_irq_oe_n_o <= 1'b1; sense_level_o <= 2'h0;
		end else begin
			press_r <= press_nxt; chg_r <= chg_nxt; irq_n_r <= irq_n_nxt; tmo_r <= tmo_nxt;
			press_indicator_oe_n_o <= ~press_nxt;
			event_irq_oe_n_o <= irq_n_nxt;
			// Invalid code 11 falls back to normal
			sense_level_o <= (cfg_nxt[TKI2C_SENS_LSB +: 2] == TKI2C_SENS_BAD) ? 2'h0
			                 : cfg_nxt[TKI2C_SENS_LSB +: 2];
		end
	end
	assign press_indicator_n_o = 8'h00;
	assign event_irq_n_o       = 1'b0;
endmodule // tki2c_device
`default_nettype wire

// ===== src/tki2c_host.sv
`timescale 1ns/1ps
`default_nettype none
// Register-controlled I2C master: one register write or register read per command.
module tki2c_host
	import tki2c_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Link
	tki2c_if.host            bus
);
	import tki2c_pkg::*;

	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} tki2c_hst_type;

	// ==========================================================
	// CTRL: [7:0] data, [15:8] index, [17:16] strap, [24] read, [31] go
	tki2c_hst_type st_r, st_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [1:0]  ph_r, ph_nxt;
	logic [3:0]  bcnt_r, bcnt_nxt;
	logic [1:0]  slot_r, slot_nxt;
	logic        rpass_r, rpass_nxt;
	logic [8:0]  sh_r, sh_nxt;
	logic [24:0] cmd_r, cmd_nxt;
	logic [7:0]  rd_r, rd_nxt;
	logic        busy_r, busy_nxt, nak_r, nak_nxt, scl_r, scl_nxt, sda_r, sda_nxt;
	logic [31:0] prdata_nxt;
	logic        wr_go;
	logic        tick;

	// Byte of a slot plus a released ninth bit; a read data slot sends all
	// ones, so the master answers the data byte with NAK
	function automatic logic [8:0] slot_byte(input logic [1:0] s, input logic r,
		input logic [24:0] c);
		unique case (s)
			2'd0:    slot_byte = {TKI2C_ADDR_HI, c[17:16], r, 1'b1};
			2'd1:    slot_byte = r ? 9'h1ff : {c[15:8], 1'b1};
			default: slot_byte = {c[7:0], 1'b1};
		endcase
	endfunction

	// Uneven quarters keep both minimum clock periods with margin while the
	// bit rate stays under the fast-mode ceiling
	function automatic logic [15:0] ph_len(input logic [1:0] p);
		unique case (p)
			2'd0:    ph_len = 16'(TKI2C_HALF_CYC / 4);
			2'd1:    ph_len = 16'(TKI2C_HALF_CYC);
			default: ph_len = 16'(TKI2C_HALF_CYC / 2);
		endcase
	endfunction

	assign wr_go = psel & penable & pwrite & (paddr == TKI2C_H_CTRL) & pwdata[31] & ~busy_r;
	assign tick  = (cnt_r == 16'd0);

	always_comb begin
		st_nxt = st_r; cnt_nxt = cnt_r; ph_nxt = ph_r; bcnt_nxt = bcnt_r;
		slot_nxt = slot_r; rpass_nxt = rpass_r; sh_nxt = sh_r; cmd_nxt = cmd_r;
		rd_nxt = rd_r; busy_nxt = busy_r; nak_nxt = nak_r; scl_nxt = scl_r; sda_nxt = sda_r;
		if (!tick) begin
			cnt_nxt = cnt_r - 16'd1;
		end else if (st_r != H_IDLE) begin
			ph_nxt  = ph_r + 2'd1;
			cnt_nxt = ph_len(ph_r + 2'd1);
		end
		unique case (st_r)
			H_IDLE: if (wr_go) begin
				cmd_nxt = pwdata[24:0]; busy_nxt = 1'b1; nak_nxt = 1'b0;
				slot_nxt = 2'd0; rpass_nxt = 1'b0; st_nxt = H_START;
				ph_nxt = 2'd0; cnt_nxt = ph_len(2'd0);
			end
			H_START: if (tick) begin
				unique case (ph_r)
					2'd0: sda_nxt = 1'b1; // released before the edge
					2'd1: scl_nxt = 1'b1;
					2'd2: sda_nxt = 1'b0; // START
					default: begin
						scl_nxt = 1'b0; st_nxt = H_BIT; bcnt_nxt = 4'd0;
						sh_nxt = slot_byte(slot_r, rpass_r, cmd_r);
					end
				endcase
			end
			H_BIT: if (tick) begin
				unique case (ph_r)
					2'd0: sda_nxt = sh_r[8]; // change while low
					2'd1: scl_nxt = 1'b1;
					2'd2: sh_nxt = {sh_r[7:0], bus.sda}; // sampled while high
					default: begin
						scl_nxt = 1'b0;
						bcnt_nxt = bcnt_r + 4'd1;
						if (bcnt_r == 4'd8) begin
							// Ninth bit done: sh_r[0] is the acknowledge
							bcnt_nxt = 4'd0;
							if (rpass_r && slot_r == 2'd1) begin
								rd_nxt = sh_r[8:1]; st_nxt = H_STOP;
							end else if (sh_r[0]) begin
								nak_nxt = 1'b1; st_nxt = H_STOP;
							end else if (cmd_r[24] && !rpass_r && slot_r == 2'd1) begin
								rpass_nxt = 1'b1; slot_nxt = 2'd0; st_nxt = H_START;
							end else if (slot_r == 2'd2) begin
								st_nxt = H_STOP;
							end else begin
								slot_nxt = slot_r + 2'd1;
								sh_nxt = slot_byte(slot_r + 2'd1, rpass_r, cmd_r);
							end
						end
					end
				endcase
			end
			default: if (tick) begin
				unique case (ph_r)
					2'd0: sda_nxt = 1'b0;
					2'd1: scl_nxt = 1'b1;
					2'd2: sda_nxt = 1'b1; // STOP
					default: begin st_nxt = H_IDLE; busy_nxt = 1'b0; end
				endcase
			end
		endcase
	end

	always_comb begin
		prdata_nxt = 32'h0;
		if (psel && !pwrite) begin
			unique case (paddr)
				TKI2C_H_STAT:  prdata_nxt = {30'h0, nak_r, busy_r};
				TKI2C_H_RDATA: prdata_nxt = {24'h0, rd_r};
				TKI2C_H_CTRL:  prdata_nxt = {7'h0, cmd_r};
				default:       prdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			st_r <= H_IDLE; slot_r <= 2'd0; rpass_r <= 1'b0; cnt_r <= 16'd0; ph_r <= 2'd0;
			sh_r <= 9'h1ff;
			cmd_r <= 25'h0; rd_r <= 8'h00; busy_r <= 1'b0; nak_r <= 1'b0;
			scl_r <= 1'b1; sda_r <= 1'b1; bcnt_r <= 4'd0;
			prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
		end else begin
			st_r <= st_nxt; slot_r <= slot_nxt; rpass_r <= rpass_nxt; cnt_r <= cnt_nxt;
			ph_r <= ph_nxt; sh_r <= sh_nxt;
			cmd_r <= cmd_nxt; rd_r <= rd_nxt; busy_r <= busy_nxt; nak_r <= nak_nxt;
			scl_r <= scl_nxt; sda_r <= sda_nxt; bcnt_r <= bcnt_nxt;
			// No wait state: ready in the first access cycle
			prdata  <= prdata_nxt;
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > TKI2C_H_RDATA);
		end
	end
	assign bus.scl_o      = 1'b0;
	assign bus.scl_oe_n   = scl_r;
	assign bus.sda_m_o    = 1'b0;
	assign bus.sda_m_oe_n = sda_r;
endmodule // tki2c_host
`default_nettype wire

// ===== verification/tki2c_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tki2c_chk (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// Bus lines
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic scl_oe_n,
	input  wire logic sda_m_oe_n,
	input  wire logic sda_s_oe_n
);
	// ==========================================================
	// Helper: clock rises within one unbroken stretch of device drive
	logic       scl_q_r;
	logic [3:0] drv_cnt_r;

	always_ff @(posedge clk_i) begin
		scl_q_r <= scl;
		if (!reset_n_i || sda_s_oe_n) begin
			drv_cnt_r <= 4'h0;
		end else if (scl && !scl_q_r) begin
			drv_cnt_r <= drv_cnt_r + 4'h1;
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	idle_after_reset_a: assert property (
		$rose(reset_n_i) |-> scl_oe_n && sda_m_oe_n && sda_s_oe_n)
		else $error("bus lines not released after reset");
	dev_sda_steady_a: assert property (
		scl && $past(scl) |-> $stable(sda_s_oe_n))
		else $error("device moved data line while clock high");
	scl_high_min_a: assert property (
		$rose(scl) |-> scl[*8])
		else $error("clock high phase too short");
	scl_low_min_a: assert property (
		$fell(scl) |-> (!scl)[*8])
		else $error("clock low phase too short");
	ack_hold_a: assert property (
		$rose(scl) && !sda_s_oe_n |-> (!sda_s_oe_n)[*8])
		else $error("device let go of data line during its clock pulse");
	start_master_a: assert property (
		scl && $past(scl) && $fell(sda) |-> $past(sda_s_oe_n) && !sda_m_oe_n)
		else $error("start edge not made by master");
	stop_master_a: assert property (
		scl && $past(scl) && $rose(sda) |-> sda_s_oe_n && sda_m_oe_n)
		else $error("stop edge with a driver still active");
	dev_drive_len_a: assert property (
		drv_cnt_r <= 4'h9)
		else $error("device held data line over too many bits");
endmodule // tki2c_chk
`default_nettype wire

// ===== verification/touch_key_i2c_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module touch_key_i2c_regs_bench;
	import tki2c_pkg::*;
	// ==========================================================
	// Signals
	logic        clk_i;
	logic        reset_n_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        slverr_q;
	logic [7:0]  sense_input_i;
	logic        hard_power_down_n_i;
	logic [7:0]  ind_oe_n;
	logic        irq_oe_n;
	logic [1:0]  sense_level;
	logic [31:0] st;
	logic [31:0] rdat;
	int          n_fail;
	int          num_checks;
	// Register table: write or read, index, data, expected read byte
	logic        row_rd  [3] = '{1'b0, 1'b1, 1'b1};
	logic [7:0]  row_idx [3] = '{TKI2C_REG_CFG, TKI2C_REG_CHEN, TKI2C_REG_CFG};
	logic [7:0]  row_dat [3] = '{8'h20, 8'h00, 8'h00};
	logic [7:0]  row_exp [3] = '{8'h00, 8'hff, 8'h20};

	// ==========================================================
	// Design
	tki2c_if link();
	tki2c_device #(.T8_CYC(100), .T32_CYC(400)) u_tki2c_device (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(link),
		.strap_i(TKI2C_STRAP_SDA), .sense_input_i(sense_input_i),
		.hard_power_down_n_i(hard_power_down_n_i), .press_indicator_n_o(),
		.press_indicator_oe_n_o(ind_oe_n), .event_irq_n_o(),
		.event_irq_oe_n_o(irq_oe_n), .sense_level_o(sense_level));
	tki2c_host u_tki2c_host (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus(link));
	tki2c_chk u_tki2c_chk (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .scl(link.scl), .sda(link.sda),
		.scl_oe_n(link.scl_oe_n), .sda_m_oe_n(link.sda_m_oe_n),
		.sda_s_oe_n(link.sda_s_oe_n));

	// ==========================================================
	// Tasks
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask

	// Setup on a rising edge; pready is read on the falling edge before the
	// rising edge that samples it, where it has settled
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk_i);
		penable <= 1'b1;
		@(negedge clk_i);
		while (pready !== 1'b1) begin
			@(negedge clk_i);
		end
		rd       = prdata;
		slverr_q = pslverr;
		@(posedge clk_i);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// One bus command, then poll busy; the watchdog bounds the poll
	task automatic cmd(input logic rd, input logic [1:0] sp, input logic [7:0] idx,
			input logic [7:0] dat);
		logic [31:0] d;
		apb(1'b1, TKI2C_H_CTRL, {1'b1, 6'h00, rd, 6'h00, sp, idx, dat}, d);
		st = 32'h1;
		while (st[0] !== 1'b0) begin
			apb(1'b0, TKI2C_H_STAT, 32'h0, st);
		end
		apb(1'b0, TKI2C_H_RDATA, 32'h0, rdat);
	endtask

	// ==========================================================
	// Clock, watchdog, sequence
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	initial begin
		repeat (110000) @(posedge clk_i);
		n_fail++;
		wrap_up();
	end

	initial begin
		n_fail = 0;
		num_checks = 0;
		reset_n_i = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sense_input_i = 8'h00;
		hard_power_down_n_i = 1'b1;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		chk("sense_level", 32'h0, sense_level);
		chk("indicators", 32'hff, ind_oe_n);
		for (int i = 0; i < 3; i++) begin
			cmd(row_rd[i], TKI2C_STRAP_SDA, row_idx[i], row_dat[i]);
			chk("nak", 32'h0, st[1]);
			if (row_rd[i]) begin
				chk("reg", row_exp[i], rdat[7:0]);
			end
		end
		chk("sense_level", 32'h1, sense_level);
		apb(1'b0, 8'h0c, 32'h0, rdat);
		chk("slverr", 32'h1, slverr_q);
		// Wrong strap bits: no answer, so no write lands
		cmd(1'b0, TKI2C_STRAP_SCL, TKI2C_REG_CFG, 8'h00);
		chk("nak", 32'h1, st[1]);
		chk("sense_level", 32'h1, sense_level);
		sense_input_i <= 8'h04;
		repeat (5) @(posedge clk_i);
		chk("indicators", 32'hfb, ind_oe_n);
		chk("irq", 32'h0, irq_oe_n);
		cmd(1'b1, TKI2C_STRAP_SDA, TKI2C_REG_PRESS, 8'h00);
		chk("press", 32'h04, rdat[7:0]);
		chk("irq", 32'h0, irq_oe_n);
		cmd(1'b1, TKI2C_STRAP_SDA, TKI2C_REG_CHANGE, 8'h00);
		chk("change", 32'h04, rdat[7:0]);
		chk("irq", 32'h1, irq_oe_n);
		cmd(1'b1, TKI2C_STRAP_SDA, TKI2C_REG_CHANGE, 8'h00);
		chk("change", 32'h00, rdat[7:0]);
		// Auto release after T8_CYC clocks low
		cmd(1'b0, TKI2C_STRAP_SDA, TKI2C_REG_IRQCFG, 8'h40);
		sense_input_i <= 8'h00;
		repeat (50) @(posedge clk_i);
		chk("irq", 32'h0, irq_oe_n);
		chk("indicators", 32'hff, ind_oe_n);
		repeat (70) @(posedge clk_i);
		chk("irq", 32'h1, irq_oe_n);
		hard_power_down_n_i <= 1'b0;
		sense_input_i       <= 8'h01;
		repeat (5) @(posedge clk_i);
		chk("sense_level", 32'h1, sense_level);
		chk("indicators", 32'hff, ind_oe_n);
		chk("irq", 32'h1, irq_oe_n);
		hard_power_down_n_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk("indicators", 32'hfe, ind_oe_n);
		chk("irq", 32'h0, irq_oe_n);
		wrap_up();
	end
endmodule // touch_key_i2c_regs_bench
`default_nettype wire
